/* File: design/itw_pkg.sv */
/*
 * itw_pkg: constants, tables and carrier types for the interval timer
 * with watchdog.
 * Assumes one 20 MHz core clock; the slow RC clock arrives as a pin
 * level and is sampled in the core domain.
 */
package itw_pkg;

	// core clock and slow oscillator rates
	localparam int unsigned REF_CLK_HZ  = 20_000_000;
	localparam int unsigned SLOW_OSC_HZ = 90_000;

	// divider and counter widths
	localparam int unsigned DIV_W     = 20;
	localparam int unsigned WDCNT_W   = 3;
	localparam int unsigned SEL_W     = 3;
	localparam int unsigned TAPLOG_W  = 5;
	localparam int unsigned HOLD_W    = 3;

	// watchdog_control field positions
	localparam int unsigned WDC_CE_BIT  = 4;
	localparam int unsigned WDC_EN_BIT  = 3;
	localparam int unsigned WDC_PS_LSB  = 0;
	localparam int unsigned WDC_PS_MSB  = 2;

	// interval_control field positions
	localparam int unsigned ICR_TAPB_LSB = 5;
	localparam int unsigned ICR_PR_BIT   = 4;
	localparam int unsigned ICR_IE_BIT   = 3;
	localparam int unsigned ICR_TAPA_LSB = 0;
	localparam int unsigned ICR_TAPA_MSB = 2;

	// reset values and fixed patterns
	localparam logic [7:0]         WDC_RESET   = 8'h00;
	localparam logic [7:0]         ICR_RESET   = 8'h00;
	localparam logic [2:0]         WDC_RSV_VAL = 3'h0;
	localparam logic [DIV_W-1:0]   DIV_ZERO    = 20'h00000;
	localparam logic [DIV_W-1:0]   DIV_ONE     = 20'h00001;
	localparam logic [DIV_W-1:0]   DIV_ONES    = 20'hFFFFF;
	localparam logic [WDCNT_W-1:0] WDCNT_ZERO  = 3'h0;
	localparam logic [WDCNT_W-1:0] WDCNT_ONE   = 3'h1;
	localparam logic [WDCNT_W-1:0] WDCNT_LAST  = 3'h7;

	// self-clearing bits stay set for this many core clocks
	localparam logic [HOLD_W-1:0]  HOLD_CYCLES = 3'h4;
	localparam logic [HOLD_W-1:0]  HOLD_ONE    = 3'h1;
	localparam logic [HOLD_W-1:0]  HOLD_ZERO   = 3'h0;

	// watchdog tick period, log2 of slow cycles: 1K..512K
	localparam logic [TAPLOG_W-1:0] WD_TAP_LOG2 [8] = '{
		5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h12, 5'h13};

	// interval tick period, log2 of slow cycles: 8..1024K
	localparam logic [TAPLOG_W-1:0] INT_TAP_LOG2 [8] = '{
		5'h03, 5'h05, 5'h07, 5'h0A, 5'h0C, 5'h0F, 5'h12, 5'h14};

	// one register write from the CPU, one cycle wide
	typedef struct packed {
		logic       wdCtrlWrite;
		logic       intervalCtrlWrite;
		logic       irqFlagWrite;
		logic [7:0] data;
	} itw_wr_s;

endpackage

/* File: design/itw_interval_timer_watchdog.sv */
/*
 * itw_interval_timer_watchdog: 20-stage slow-clock divider with interval
 * tick, interval interrupt flag and a 3-bit watchdog with timed change
 * protection and a safety level fuse.
 * Assumes the CPU gives one-cycle write strobes on ref_clk, a one-cycle
 * watchdog restart strobe, a static fuse level and the reset status flag
 * from logic on the same clock; slowOscClk is an asynchronous pin.
 */
`timescale 1ns/10ps
`default_nettype none

module itw_interval_timer_watchdog
	import itw_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        slowOscClk,
	input  wire logic        safetyLevelFuse,
	input  wire logic        watchdogResetFlag,
	input  wire logic        watchdogRestart,
	input  wire logic        irqServiced,
	input  wire itw_wr_s     cpuWrite,
	output logic [7:0]       wdCtrlRead,
	output logic [7:0]       intervalCtrlRead,
	output logic             intervalIrqFlag,
	output logic             intervalIrq,
	output logic             intervalOutClock,
	output logic             watchdogTickClock,
	output logic             systemReset
);

	// whole module state
	typedef struct packed {
		logic                 slowSync1;
		logic                 slowSync2;
		logic                 slowPrev;
		logic [DIV_W-1:0]     div;
		logic [WDCNT_W-1:0]   wdCount;
		logic                 wdEnable;
		logic                 changeEnable;
		logic [HOLD_W-1:0]    ceHold;
		logic [SEL_W-1:0]     periodSel;
		logic [7:0]           intervalCtrl;
		logic [HOLD_W-1:0]    prHold;
		logic                 irqFlag;
		logic                 intTick;
		logic                 wdTick;
		logic                 sysReset;
	} itw_state_s;

	itw_state_s state;
	itw_state_s next_state;

	// reserved read-back field and the flag's write-one-to-clear bit
	localparam int unsigned WDC_RSV_MSB  = 7;
	localparam int unsigned WDC_RSV_LSB  = 5;
	localparam int unsigned IRQ_FLAG_BIT = 0;

	// true on the slow edge that completes a period of 2**lg cycles
	function automatic logic tapReached(
		input logic [DIV_W-1:0]    cnt,
		input logic [TAPLOG_W-1:0] lg
	);
		logic [DIV_W-1:0] mask;
		mask = ~(DIV_ONES << lg);
		return (cnt & mask) == mask;
	endfunction

	// decoded helpers
	logic wdActive;
	logic slowEdge;
	logic armWrite;
	logic wantDisable;
	logic lockedOn;
	logic [TAPLOG_W-1:0] wdLog;
	logic [TAPLOG_W-1:0] intLog;

	// effective enable, fuse lock and write decode
	always_comb begin
		lockedOn   = safetyLevelFuse | watchdogResetFlag;
		wdActive   = state.wdEnable | lockedOn;
		slowEdge   = state.slowSync2 & ~state.slowPrev;
		armWrite   = cpuWrite.wdCtrlWrite
			& cpuWrite.data[WDC_CE_BIT] & cpuWrite.data[WDC_EN_BIT];
		wantDisable = cpuWrite.wdCtrlWrite & ~cpuWrite.data[WDC_EN_BIT];
		wdLog      = WD_TAP_LOG2[state.periodSel];
		intLog     = INT_TAP_LOG2[state.intervalCtrl[ICR_TAPA_MSB:
			ICR_TAPA_LSB]];
	end

	// next-state logic
	always_comb begin
		next_state = state;

		// pin sampling of the slow oscillator
		next_state.slowSync1 = slowOscClk;
		next_state.slowSync2 = state.slowSync1;
		next_state.slowPrev  = state.slowSync2;

		// divider advances on each slow edge, wraps freely
		next_state.intTick = 1'b0;
		next_state.wdTick  = 1'b0;
		if (slowEdge) begin
			next_state.div     = state.div + DIV_ONE;
			next_state.intTick = tapReached(state.div, intLog);
			next_state.wdTick  = tapReached(state.div, wdLog);
		end

		// interval control write and restart bit
		if (state.prHold != HOLD_ZERO) begin
			next_state.prHold = state.prHold - HOLD_ONE;
			if (state.prHold == HOLD_ONE) begin
				next_state.intervalCtrl[ICR_PR_BIT] = 1'b0;
			end
		end
		if (cpuWrite.intervalCtrlWrite) begin
			next_state.intervalCtrl = cpuWrite.data;
			if (cpuWrite.data[ICR_PR_BIT]) begin
				next_state.prHold = HOLD_CYCLES;
				if (!wdActive) begin
					next_state.div = DIV_ZERO;
				end
			end
		end

		// change-enable countdown
		if (state.ceHold != HOLD_ZERO) begin
			next_state.ceHold = state.ceHold - HOLD_ONE;
			if (state.ceHold == HOLD_ONE) begin
				next_state.changeEnable = 1'b0;
			end
		end

		// watchdog control write with timed protection
		if (cpuWrite.wdCtrlWrite) begin
			if (state.changeEnable) begin
				next_state.periodSel = cpuWrite.data[WDC_PS_MSB:
					WDC_PS_LSB];
			end
			if (cpuWrite.data[WDC_EN_BIT]) begin
				next_state.wdEnable = 1'b1;
			end else if (wantDisable && state.changeEnable
				&& !lockedOn) begin
				next_state.wdEnable = 1'b0;
			end
		end
		if (armWrite) begin
			next_state.changeEnable = 1'b1;
			next_state.ceHold       = HOLD_CYCLES;
		end

		// watchdog counter and overflow reset
		next_state.sysReset = 1'b0;
		if (!wdActive) begin
			next_state.wdCount = WDCNT_ZERO;
		end else if (watchdogRestart) begin
			next_state.wdCount = WDCNT_ZERO;
		end else if (state.wdTick) begin
			next_state.wdCount = state.wdCount + WDCNT_ONE;
			if (state.wdCount == WDCNT_LAST) begin
				next_state.sysReset = 1'b1;
			end
		end

		// interval flag: a new tick wins over a clear
		if (irqServiced || (cpuWrite.irqFlagWrite
			&& cpuWrite.data[IRQ_FLAG_BIT])) begin
			next_state.irqFlag = 1'b0;
		end
		if (state.intTick) begin
			next_state.irqFlag = 1'b1;
		end
	end

	// state register, chip reset clears everything
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state              <= '0;
			state.intervalCtrl <= ICR_RESET;
			state.div          <= DIV_ZERO;
			state.wdCount      <= WDCNT_ZERO;
		end else begin
			state <= next_state;
		end
	end

	// register read-back and outputs
	always_comb begin
		wdCtrlRead = WDC_RESET;
		wdCtrlRead[WDC_RSV_MSB:WDC_RSV_LSB] = WDC_RSV_VAL;
		wdCtrlRead[WDC_CE_BIT] = state.changeEnable;
		wdCtrlRead[WDC_EN_BIT] = wdActive;
		wdCtrlRead[WDC_PS_MSB:WDC_PS_LSB] = state.periodSel;
	end
	assign intervalCtrlRead  = state.intervalCtrl;
	assign intervalIrqFlag   = state.irqFlag;
	assign intervalIrq = state.irqFlag
		& state.intervalCtrl[ICR_IE_BIT];
	assign intervalOutClock  = state.intTick;
	assign watchdogTickClock = state.wdTick;
	assign systemReset       = state.sysReset;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence armSeq;
		cpuWrite.wdCtrlWrite && cpuWrite.data[WDC_CE_BIT]
			&& cpuWrite.data[WDC_EN_BIT];
	endsequence

	sequence zeroWriteSeq;
		cpuWrite.wdCtrlWrite && !cpuWrite.data[WDC_EN_BIT]
			&& !safetyLevelFuse && !watchdogResetFlag;
	endsequence

	// change-enable stands in the four cycles after the arming write
	sequence timedDisableSeq;
		armSeq ##[1:4] zeroWriteSeq;
	endsequence

	a_timed_disable: assert property (
		timedDisableSeq |=> !wdCtrlRead[WDC_EN_BIT])
		else $error("timed disable sequence did not disable watchdog");

	a_ce_hold: assert property (
		$rose(wdCtrlRead[WDC_CE_BIT]) |-> wdCtrlRead[WDC_CE_BIT][*4])
		else $error("change enable dropped before four clocks");

	a_ce_drop: assert property (
		(armSeq ##1 (!armSeq)[*4]) |=> !wdCtrlRead[WDC_CE_BIT])
		else $error("change enable still set after four clocks");

	a_untimed_keep: assert property (
		wdCtrlRead[WDC_EN_BIT] && !wdCtrlRead[WDC_CE_BIT]
			&& cpuWrite.wdCtrlWrite |=> wdCtrlRead[WDC_EN_BIT])
		else $error("watchdog disabled without change enable");

	a_period_guard: assert property (
		cpuWrite.wdCtrlWrite && !wdCtrlRead[WDC_CE_BIT]
			|=> $stable(wdCtrlRead[WDC_PS_MSB:WDC_PS_LSB]))
		else $error("period changed without change enable");

	a_level_two: assert property (
		safetyLevelFuse |-> wdCtrlRead[WDC_EN_BIT])
		else $error("watchdog disabled in safety level 2");

	a_flag_force: assert property (
		watchdogResetFlag |-> wdCtrlRead[WDC_EN_BIT])
		else $error("reset flag did not force enable");

	a_rsv_zero: assert property (
		wdCtrlRead[WDC_RSV_MSB:WDC_RSV_LSB] == WDC_RSV_VAL)
		else $error("reserved bits read nonzero");

	a_wd_overflow: assert property (
		wdCtrlRead[WDC_EN_BIT] && watchdogTickClock && !watchdogRestart
			&& state.wdCount == WDCNT_LAST |=> systemReset)
		else $error("counter overflow gave no system reset");

	a_restart_clear: assert property (
		watchdogRestart |=> state.wdCount == WDCNT_ZERO)
		else $error("restart strobe did not clear counter");

	a_off_clear: assert property (
		!wdCtrlRead[WDC_EN_BIT] |=> state.wdCount == WDCNT_ZERO)
		else $error("counter not cleared while disabled");

	a_flag_set: assert property (
		intervalOutClock |=> intervalIrqFlag)
		else $error("interval tick did not set flag");

	a_irq_mask: assert property (
		intervalIrq |-> intervalIrqFlag
			&& intervalCtrlRead[ICR_IE_BIT])
		else $error("interrupt raised while masked");

	a_div_restart: assert property (
		cpuWrite.intervalCtrlWrite && cpuWrite.data[ICR_PR_BIT]
			&& !wdCtrlRead[WDC_EN_BIT] |=> state.div == DIV_ZERO)
		else $error("divider not restarted");

	a_pr_clear: assert property (
		cpuWrite.intervalCtrlWrite && cpuWrite.data[ICR_PR_BIT]
			##1 (!cpuWrite.intervalCtrlWrite)[*4]
			|=> !intervalCtrlRead[ICR_PR_BIT])
		else $error("restart bit did not self clear");

	a_ce_arm: assert property (
		armSeq |=> wdCtrlRead[WDC_CE_BIT])
		else $error("arming write did not set change enable");

	a_enable_set: assert property (
		cpuWrite.wdCtrlWrite && cpuWrite.data[WDC_EN_BIT]
			|=> wdCtrlRead[WDC_EN_BIT])
		else $error("write of one did not enable watchdog");

	a_period_load: assert property (
		cpuWrite.wdCtrlWrite && wdCtrlRead[WDC_CE_BIT]
			|=> wdCtrlRead[WDC_PS_MSB:WDC_PS_LSB]
			== $past(cpuWrite.data[WDC_PS_MSB:WDC_PS_LSB]))
		else $error("period not taken while change enable set");

	a_irq_clear: assert property (
		(irqServiced || (cpuWrite.irqFlagWrite
			&& cpuWrite.data[IRQ_FLAG_BIT])) && !intervalOutClock
			|=> !intervalIrqFlag)
		else $error("interval flag not cleared");

	a_wd_advance: assert property (
		wdCtrlRead[WDC_EN_BIT] && watchdogTickClock && !watchdogRestart
			&& state.wdCount != WDCNT_LAST
			|=> state.wdCount == $past(state.wdCount) + WDCNT_ONE)
		else $error("watchdog tick did not advance counter");

	a_reset_single: assert property (
		systemReset |=> !systemReset)
		else $error("system reset wider than one cycle");

	a_tick_single: assert property (
		intervalOutClock |=> !intervalOutClock)
		else $error("interval tick wider than one cycle");

endmodule // itw_interval_timer_watchdog

`default_nettype wire

/* File: test/tb_top.sv */
/*
 * tb_top: self-checking bench for the interval timer with watchdog.
 * Assumes the design answers register writes one clock later and makes
 * one-cycle tick pulses; the slow oscillator pin is made here at 8 core
 * clocks per slow period to keep the run short.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import itw_pkg::*;

	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       slowOscClk = 1'b0;
	logic [1:0] slowDiv = 2'h0;
	logic       safetyLevelFuse = 1'b0;
	logic       watchdogResetFlag = 1'b0;
	logic       watchdogRestart = 1'b0;
	logic       irqServiced = 1'b0;
	itw_wr_s    cpuWrite = '0;
	logic [7:0] wdCtrlRead;
	logic [7:0] intervalCtrlRead;
	logic       intervalIrqFlag;
	logic       intervalIrq;
	logic       intervalOutClock;
	logic       watchdogTickClock;
	logic       systemReset;
	int         badCount = 0;
	int         nTests = 0;
	int         cycles = 0;

	itw_interval_timer_watchdog u_dut (
		.ref_clk          (ref_clk),
		.sys_rst          (sys_rst),
		.slowOscClk       (slowOscClk),
		.safetyLevelFuse  (safetyLevelFuse),
		.watchdogResetFlag(watchdogResetFlag),
		.watchdogRestart  (watchdogRestart),
		.irqServiced      (irqServiced),
		.cpuWrite         (cpuWrite),
		.wdCtrlRead       (wdCtrlRead),
		.intervalCtrlRead (intervalCtrlRead),
		.intervalIrqFlag  (intervalIrqFlag),
		.intervalIrq      (intervalIrq),
		.intervalOutClock (intervalOutClock),
		.watchdogTickClock(watchdogTickClock),
		.systemReset      (systemReset)
	);

	// core clock, 50 ns period
	always #25 ref_clk = ~ref_clk;

	// slow oscillator pin, toggles every four core clocks
	always @(negedge ref_clk) begin
		slowDiv <= slowDiv + 2'h1;
		if (slowDiv == 2'h3) slowOscClk <= ~slowOscClk;
	end

	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			badCount = badCount + 1;
			giveVerdict();
		end
	end

	task automatic giveVerdict();
		if (badCount == 0 && nTests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		nTests = nTests + 1;
		if (seen !== exp) begin
			badCount = badCount + 1;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// one write strobe; returns once the readback has had its edge
	task automatic wrReg(input int kind, input logic [7:0] d);
		@(negedge ref_clk);
		cpuWrite.wdCtrlWrite = (kind == 0);
		cpuWrite.intervalCtrlWrite = (kind == 1);
		cpuWrite.irqFlagWrite = (kind == 2);
		cpuWrite.data = d;
		@(negedge ref_clk);
		cpuWrite = '0;
		@(negedge ref_clk);
	endtask

	task automatic doReset();
		sys_rst = 1'b1;
		tick(8);
		sys_rst = 1'b0;
		tick(1);
	endtask

	// counts core clocks until the chosen pulse is seen
	task automatic waitFor(input int which, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (!((which == 0) ? intervalOutClock === 1'b1 :
			(which == 1) ? watchdogTickClock === 1'b1 :
			systemReset === 1'b1) && n < 20000);
	endtask

	task automatic testResetState();
		check("wdctrl", wdCtrlRead, 8'h00);
		check("ivctrl", intervalCtrlRead, 8'h00);
		check("sysreset", systemReset, 1'b0);
	endtask

	task automatic testInterval();
		int n;
		wrReg(1, 8'h00);
		waitFor(0, n);
		waitFor(0, n);
		check("ival gap", n, 64);
		tick(1);
		check("flag set", intervalIrqFlag, 1'b1);
		check("irq masked", intervalIrq, 1'b0);
		wrReg(1, 8'h08);
		check("irq on", intervalIrq, 1'b1);
		wrReg(2, 8'h01);
		check("flag w1c", intervalIrqFlag, 1'b0);
		waitFor(0, n);
		tick(1);
		@(negedge ref_clk) irqServiced = 1'b1;
		@(negedge ref_clk) irqServiced = 1'b0;
		check("flag svc", intervalIrqFlag, 1'b0);
		waitFor(0, n);
		tick(20);
		wrReg(1, 8'h18);
		tick(2);
		check("restart held", intervalCtrlRead[4], 1'b1);
		tick(1);
		check("restart clr", intervalCtrlRead[4], 1'b0);
		waitFor(0, n);
		check("restart gap", n > 44, 1'b1);
	endtask

	task automatic testWdReg();
		wrReg(0, 8'hFF);
		check("arm", wdCtrlRead, 8'h18);
		tick(2);
		check("ce held", wdCtrlRead[4], 1'b1);
		tick(1);
		check("ce clr", wdCtrlRead, 8'h08);
		wrReg(0, 8'h00);
		check("late off", wdCtrlRead, 8'h08);
		@(negedge ref_clk) watchdogRestart = 1'b1;
		@(negedge ref_clk) watchdogRestart = 1'b0;
		wrReg(0, 8'h18);
		wrReg(0, 8'h0A);
		tick(4);
		check("period", wdCtrlRead, 8'h0A);
		wrReg(0, 8'h18);
		wrReg(0, 8'h00);
		check("off", wdCtrlRead[3], 1'b0);
		tick(4);
		check("off all", wdCtrlRead, 8'h00);
	endtask

	task automatic offSeq(input string name, input logic [7:0] exp);
		wrReg(0, 8'h18);
		wrReg(0, 8'h00);
		tick(4);
		check(name, wdCtrlRead, exp);
	endtask

	task automatic testLevels();
		safetyLevelFuse = 1'b1;
		doReset();
		check("lvl2 init", wdCtrlRead, 8'h08);
		offSeq("lvl2 off", 8'h08);
		safetyLevelFuse = 1'b0;
		watchdogResetFlag = 1'b1;
		doReset();
		check("flag init", wdCtrlRead, 8'h08);
		offSeq("flag off", 8'h08);
		watchdogResetFlag = 1'b0;
		tick(1);
		check("flag gone", wdCtrlRead, 8'h08);
		offSeq("lvl1 off", 8'h00);
	endtask

	task automatic testWatchdog();
		int n;
		int k;
		doReset();
		wrReg(1, 8'h10);
		wrReg(0, 8'h08);
		waitFor(1, n);
		waitFor(1, n);
		check("wd period", n, 8192);
		watchdogRestart = 1'b1;
		@(negedge ref_clk) watchdogRestart = 1'b0;
		k = 0;
		n = 0;
		while (systemReset !== 1'b1 && n < 80000) begin
			@(negedge ref_clk);
			n++;
			if (watchdogTickClock === 1'b1) k++;
		end
		check("ticks to reset", k, 8);
		tick(1);
		check("reset pulse", systemReset, 1'b0);
	endtask

	// main sequence
	initial begin
		doReset();
		testResetState();
		testInterval();
		testWdReg();
		testLevels();
		testWatchdog();
		giveVerdict();
	end

endmodule // tb_top

`default_nettype wire
